//--- logic/cie_defines.svh
// Constants of the CAM instruction executor: sizes, register map,
// flag and enable bit positions, error codes, op codes, timing.
// Assumes inclusion by cie_pkg, the design modules and the testbench.
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH
// ----------------------------------------------------------------
// Table size
// ----------------------------------------------------------------
`define CIE_TBL_DEPTH   16
`define CIE_IDX_W       4
`define CIE_CNT_W       5
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CIE_R_IO0       4'h0
`define CIE_R_IO1       4'h1
`define CIE_R_IO2       4'h2
`define CIE_R_IO3       4'h3
`define CIE_R_OP        4'h4
`define CIE_R_FLAG      4'h5
`define CIE_R_ERR       4'h6
`define CIE_R_INT       4'h7
`define CIE_R_PTR       4'h8
`define CIE_R_AFP       4'h9
// ----------------------------------------------------------------
// Flag bits and interrupt enable bits
// ----------------------------------------------------------------
`define CIE_F_INTEN     0
`define CIE_F_MATCH     1
`define CIE_F_INIT      2
`define CIE_F_BUF       3
`define CIE_F_QEMPTY    4
`define CIE_F_QFULL     5
`define CIE_F_TFULL     6
`define CIE_F_ERR       7
`define CIE_F_AFULL     8
`define CIE_F_DONE      10
`define CIE_IE_QFULL    0
`define CIE_IE_TFULL    1
`define CIE_IE_CHECK    2
`define CIE_IE_INIT     3
`define CIE_IE_FAST     4
`define CIE_IE_AFULL    5
`define CIE_IE_ILL      7
// ----------------------------------------------------------------
// Error codes, op codes, reset values
// ----------------------------------------------------------------
`define CIE_E_NONE      16'hFFFF
`define CIE_E_ILL       16'hFFFD
`define CIE_E_NOINIT    16'hFFFB
`define CIE_E_QNE       16'hFFFA
`define CIE_E_TFULL     16'hFFF9
`define CIE_E_QFULL     16'hFFF8
`define CIE_OP_INS_A    16'h0000
`define CIE_OP_INS_B    16'h000F
`define CIE_OP_DEL_A    16'h0001
`define CIE_OP_DEL_B    16'h000E
`define CIE_OP_CHECK    16'h0006
`define CIE_OP_INIT     16'h000B
`define CIE_OP_FAST     16'h0004
`define CIE_OP_BUF      16'h0005
`define CIE_OP_COUNT    16'h0003
`define CIE_OP_MASK_A   16'h0002
`define CIE_OP_MASK_B   16'h000D
`define CIE_OP_AFP      16'h0007
`define CIE_OP_PTR      16'h0009
`define CIE_RST_AFP     14'h3FFF
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CIE_INIT_TIME_MS 120
`define CIE_CLK_HZ       40000000
`define CIE_INIT_CYCLES  (`CIE_INIT_TIME_MS * (`CIE_CLK_HZ / 1000))
`endif

//--- logic/cie_pkg.sv
// Types shared by the CAM instruction executor and its table.
// Assumes cie_defines.svh is on the include path.
`include "cie_defines.svh"
package cie_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOOK = 4'h2,
        ST_EXEC = 4'h4,
        ST_INIT = 4'h8
    } cie_state_e;
    typedef logic [`CIE_IDX_W-1:0] cie_idx_t;
    typedef struct packed {
        logic        wr;
        logic        clr;
        cie_idx_t    idx;
        logic [63:0] data;
    } cie_wr_s;
    typedef struct packed {
        logic        hit;
        cie_idx_t    hit_idx;
        logic [63:0] hit_data;
        logic        free_ok;
        cie_idx_t    free_idx;
    } cie_look_s;
    typedef struct packed {
        logic [`CIE_TBL_DEPTH-1:0][63:0] ent;
        logic [`CIE_TBL_DEPTH-1:0]       vld;
        cie_look_s                       look;
    } cie_tbl_s;
    typedef struct packed {
        cie_state_e             state;
        logic                   ack;
        logic [31:0]            dat;
        logic                   irq;
        logic [3:0][15:0]       io;
        logic [15:0]            op;
        logic [63:0]            key;
        logic [63:0]            mask;
        logic [7:0]             int_en;
        logic [15:0]            err;
        logic                   match;
        logic                   init;
        logic                   bufm;
        logic                   errf;
        logic                   afull;
        logic                   done;
        logic                   block;
        logic [`CIE_CNT_W-1:0]  cnt;
        logic [13:0]            afp;
        logic [13:0]            ptr;
        logic [31:0]            tmr;
    } cie_main_s;
endpackage

//--- logic/cie_table.sv
// Entry table: storage with valid bits and a masked parallel search.
// Assumes key and mask stay put while the search result is used.
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_table (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // Search
    input  wire logic [63:0]   key_i,
    input  wire logic [63:0]   mask_i,
    // Update
    input  wire cie_pkg::cie_wr_s   wr_i,
    // Registered search result
    output cie_pkg::cie_look_s look_o
);
    cie_pkg::cie_tbl_s q;
    cie_pkg::cie_tbl_s d;

    // ----------------------------------------------------------------
    // Search and update
    // ----------------------------------------------------------------
    // Lowest index wins; search sees the table before this cycle's write
    always_comb begin
        d = q;
        d.look.hit = 1'b0;
        d.look.free_ok = 1'b0;
        d.look.hit_idx = '0;
        d.look.free_idx = '0;
        d.look.hit_data = '0;
        for (int i = `CIE_TBL_DEPTH - 1; i >= 0; i--) begin
            if (q.vld[i] && (((q.ent[i] ^ key_i) & ~mask_i) == 64'h0)) begin
                d.look.hit = 1'b1;
                d.look.hit_idx = `CIE_IDX_W'(i);
                d.look.hit_data = q.ent[i];
            end
            if (!q.vld[i]) begin
                d.look.free_ok = 1'b1;
                d.look.free_idx = `CIE_IDX_W'(i);
            end
        end
        if (wr_i.wr) begin
            d.ent[wr_i.idx] = wr_i.data;
            d.vld[wr_i.idx] = 1'b1;
        end
        if (wr_i.clr) begin
            d.vld[wr_i.idx] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign look_o = q.look;
endmodule // cie_table

//--- logic/cie_exec.sv
// CAM instruction executor: register file on a Wishbone slave,
// op code decode and execution against the entry table.
// Assumes a classic Wishbone master on the same clock.
//
// How it works
// - Operands in data regs, then op code
// - Decode op codes into instruction actions
// - Op write clears error, code FFFF
// - Data reg 3 bit 15 is top
// - Buffered insert stored, matchable at once
// - Buffered insert when queue full errors FFF8
// - Fast insert writes straight into table
// - Fast insert when table full errors FFF9
// - Buffered insert replaces identical pattern entry
// - Delete compares unmasked bits, invalidates match
// - Check hit sets flag, returns entry
// - Check miss clears flag; interrupt on done
// - Check completes within sixteen cycles
// - Initialize sets initialized, buffered flags, interrupt
// - Registers read-only while initialize runs
// - Fast mode needs empty queue, else FFFA
// - Fast mode clears mode, initialized flags
// - Buffered mode accepted any time
// - Mixed loading blocks matching until initialize
// - Latest queued operation wins conflicts
// - Entry count returned in data reg 0
// - Mask load copies operand; one excludes bit
// - Almost-full threshold; flag and interrupt on reach
// - Threshold reprogrammable without disturbing matching
// - Fast-read pointer from data reg 0
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_exec #(
    parameter int unsigned INIT_CYCLES = `CIE_INIT_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [5:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Interrupt
    output logic             IRQ_O
);
    cie_pkg::cie_main_s q;
    cie_pkg::cie_main_s d;
    cie_pkg::cie_wr_s   tw;
    cie_pkg::cie_look_s look;
    logic [15:0]        flags;
    logic [15:0]        rd;
    logic [3:0]         idx;
    logic               tfull;
    logic [`CIE_CNT_W-1:0] cnt_inc;

    // Queue drains within the insert itself, so it never holds entries
    localparam logic QEMPTY = 1'b1;

    // ----------------------------------------------------------------
    // Entry table
    // ----------------------------------------------------------------
    cie_table u_table (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .key_i   (q.key),
        .mask_i  (q.mask),
        .wr_i    (tw),
        .look_o  (look)
    );

    // ----------------------------------------------------------------
    // Flag word
    // ----------------------------------------------------------------
    assign tfull = (q.cnt == `CIE_CNT_W'(`CIE_TBL_DEPTH));
    assign cnt_inc = q.cnt + `CIE_CNT_W'(1);

    always_comb begin
        flags = 16'h0000;
        flags[`CIE_F_INTEN]  = |q.int_en;
        flags[`CIE_F_MATCH]  = q.match;
        flags[`CIE_F_INIT]   = q.init;
        flags[`CIE_F_BUF]    = q.bufm;
        flags[`CIE_F_QEMPTY] = QEMPTY;
        flags[`CIE_F_QFULL]  = q.bufm & tfull;
        flags[`CIE_F_TFULL]  = tfull;
        flags[`CIE_F_ERR]    = q.errf;
        flags[`CIE_F_AFULL]  = q.afull;
        flags[`CIE_F_DONE]   = q.done;
    end

    // Byte lanes 0 and 1 carry the 16-bit registers
    function automatic logic [15:0] merge(input logic [15:0] old);
        merge = {SEL_I[1] ? DAT_I[15:8] : old[15:8],
                 SEL_I[0] ? DAT_I[7:0]  : old[7:0]};
    endfunction

    // ----------------------------------------------------------------
    // Bus, decode and execution
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        tw = '0;
        rd = 16'h0000;
        idx = ADR_I[5:2];
        d.ack = 1'b0;
        unique case (idx)
            `CIE_R_IO0, `CIE_R_IO1,
            `CIE_R_IO2, `CIE_R_IO3: rd = q.io[idx[1:0]];
            `CIE_R_OP:   rd = q.op;
            `CIE_R_FLAG: rd = flags;
            `CIE_R_ERR:  rd = q.err;
            `CIE_R_INT:  rd = {8'h00, q.int_en};
            `CIE_R_PTR:  rd = {2'b00, q.ptr};
            `CIE_R_AFP:  rd = {2'b00, q.afp};
            default:     rd = 16'h0000;
        endcase
        if (CYC_I && STB_I && !q.ack) begin
            d.ack = 1'b1;
            d.dat = {16'h0000, rd};
            // Writes are dropped but still acked while initializing
            if (WE_I && q.state != cie_pkg::ST_INIT) begin
                unique case (idx)
                    `CIE_R_IO0, `CIE_R_IO1,
                    `CIE_R_IO2, `CIE_R_IO3: begin
                        d.io[idx[1:0]] = merge(q.io[idx[1:0]]);
                    end
                    `CIE_R_INT: begin
                        // Enables sit in byte lane 0 only
                        if (SEL_I[0]) begin
                            d.int_en = DAT_I[7:0];
                        end
                    end
                    `CIE_R_OP: begin
                        // Op writes while busy are ignored
                        if (q.state == cie_pkg::ST_IDLE) begin
                            d.op = merge(q.op);
                            d.key = q.io;
                            d.errf = 1'b0;
                            d.err = `CIE_E_NONE;
                            d.done = 1'b0;
                            d.irq = 1'b0;
                            d.state = cie_pkg::ST_LOOK;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        unique case (q.state)
            cie_pkg::ST_IDLE: begin
            end
            cie_pkg::ST_LOOK: begin
                // Table searches the latched key here; its registered result is used in ST_EXEC
                d.state = cie_pkg::ST_EXEC;
            end
            cie_pkg::ST_EXEC: begin
                d.state = cie_pkg::ST_IDLE;
                d.done = 1'b1;
                case (q.op)
                    `CIE_OP_INS_A, `CIE_OP_INS_B: begin
                        if (q.bufm) begin
                            if (look.hit) begin
                                // Same pattern: latest insert replaces it
                                tw.wr = 1'b1;
                                tw.idx = look.hit_idx;
                                tw.data = q.key;
                            end else if (look.free_ok) begin
                                tw.wr = 1'b1;
                                tw.idx = look.free_idx;
                                tw.data = q.key;
                                d.cnt = cnt_inc;
                            end else begin
                                d.err = `CIE_E_QFULL;
                                d.errf = 1'b1;
                                if (q.int_en[`CIE_IE_QFULL]) begin
                                    d.irq = 1'b1;
                                end
                            end
                        end else if (tfull) begin
                            d.err = `CIE_E_TFULL;
                            d.errf = 1'b1;
                            if (q.int_en[`CIE_IE_TFULL]) begin
                                d.irq = 1'b1;
                            end
                        end else begin
                            // No duplicate check: host keeps patterns unique
                            tw.wr = 1'b1;
                            tw.idx = look.free_idx;
                            tw.data = q.key;
                            d.cnt = cnt_inc;
                        end
                        if (tw.wr && !(q.bufm && look.hit) &&
                            14'(cnt_inc) == q.afp) begin
                            d.afull = 1'b1;
                            if (q.int_en[`CIE_IE_AFULL]) begin
                                d.irq = 1'b1;
                            end
                        end
                    end
                    `CIE_OP_DEL_A, `CIE_OP_DEL_B: begin
                        if (look.hit) begin
                            tw.clr = 1'b1;
                            tw.idx = look.hit_idx;
                            d.cnt = q.cnt - `CIE_CNT_W'(1);
                        end
                    end
                    `CIE_OP_CHECK: begin
                        // Done two cycles after accept, well inside 16
                        if (!q.block && look.hit) begin
                            d.match = 1'b1;
                            d.io = look.hit_data;
                        end else begin
                            d.match = 1'b0;
                        end
                        if (q.block) begin
                            d.err = `CIE_E_NOINIT;
                            d.errf = 1'b1;
                        end
                        if (q.int_en[`CIE_IE_CHECK]) begin
                            d.irq = 1'b1;
                        end
                    end
                    `CIE_OP_INIT: begin
                        d.state = cie_pkg::ST_INIT;
                        d.done = 1'b0;
                        d.tmr = 32'h0000_0000;
                    end
                    `CIE_OP_FAST: begin
                        if (QEMPTY) begin
                            d.bufm = 1'b0;
                            d.init = 1'b0;
                            d.block = 1'b1;
                        end else begin
                            d.err = `CIE_E_QNE;
                            d.errf = 1'b1;
                            if (q.int_en[`CIE_IE_FAST]) begin
                                d.irq = 1'b1;
                            end
                        end
                    end
                    `CIE_OP_BUF: begin
                        // Block from fast loading stays until initialize
                        d.bufm = 1'b1;
                    end
                    `CIE_OP_COUNT: begin
                        d.io[0] = 16'(q.cnt);
                    end
                    `CIE_OP_MASK_A, `CIE_OP_MASK_B: begin
                        // Old entries are not re-sorted; host reruns init
                        d.mask = q.key;
                    end
                    `CIE_OP_AFP: begin
                        // Threshold moves and almost-full flag clears; table search untouched
                        d.afp = q.io[0][13:0];
                        d.afull = 1'b0;
                    end
                    `CIE_OP_PTR: begin
                        d.ptr = q.io[0][13:0];
                    end
                    default: begin
                        d.err = `CIE_E_ILL;
                        d.errf = 1'b1;
                        if (q.int_en[`CIE_IE_ILL]) begin
                            d.irq = 1'b1;
                        end
                    end
                endcase
            end
            cie_pkg::ST_INIT: begin
                d.tmr = q.tmr + 32'h0000_0001;
                if (q.tmr == INIT_CYCLES - 1) begin
                    d.init = 1'b1;
                    d.bufm = 1'b1;
                    d.block = 1'b0;
                    d.done = 1'b1;
                    d.state = cie_pkg::ST_IDLE;
                    if (q.int_en[`CIE_IE_INIT]) begin
                        d.irq = 1'b1;
                    end
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            q       <= '0;
            q.state <= cie_pkg::ST_IDLE;
            q.err   <= `CIE_E_NONE;
            q.init  <= 1'b1;
            q.bufm  <= 1'b1;
            q.afp   <= `CIE_RST_AFP;
        end else begin
            q <= d;
        end
    end

    assign DAT_O = q.dat;
    assign ACK_O = q.ack;
    assign IRQ_O = q.irq;
endmodule // cie_exec

//--- verif/cie_exec_checker.sv
// Checker: bus and result relations at the executor ports.
// Assumes a classic single-cycle bus master on the same clock.
`timescale 1ns/1ps
module cie_exec_checker #(
    parameter int unsigned INIT_CYCLES = 10
) (
    // Clock and reset
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    // Bus
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [5:0]  ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        IRQ_O
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    wire logic rd = ACK_O && !WE_I;
    a_ack_answer: assert property (
        CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack missing");
    a_ack_pulse: assert property (
        ACK_O |=> !ACK_O) else $error("ack too long");
    a_ack_cause: assert property (
        ACK_O |-> $past(CYC_I && STB_I)) else $error("ack unasked");
    a_dat_high_zero: assert property (
        ACK_O |-> DAT_O[31:16] == 16'h0000) else $error("high data set");
    a_irq_op_clear: assert property (
        $fell(IRQ_O) |-> ACK_O && WE_I && ADR_I[5:2] == 4'h4)
        else $error("irq fell without op write");
    a_unmapped_zero: assert property (
        rd && ADR_I[5:2] > 4'h9 |-> DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_flag_fixed: assert property (
        rd && ADR_I[5:2] == 4'h5 |-> DAT_O[4] && DAT_O[15:11] == 5'h00)
        else $error("flag fixed bits wrong");
    a_err_code_form: assert property (
        rd && ADR_I[5:2] == 4'h6 |-> DAT_O[15:3] == 13'h1FFF)
        else $error("error code out of set");
endmodule // cie_exec_checker

bind cie_exec cie_exec_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ_O(IRQ_O));

//--- verif/cie_host.sv
// Host model: single-cycle bus master on the control registers.
// Assumes a tb top module that offers a hang task.
`timescale 1ns/1ps
module cie_host (
    // Clock
    input  wire logic        clk_i,
    // Bus master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [5:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 6'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // Request held until ack sampled high, then released
    task automatic xfer(input logic w, input logic [3:0] idx,
                        input logic [15:0] d, output logic [15:0] q);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'h3;
        dat_o <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 100);
        if (ack_i !== 1'b1) tb.hang();
        q = dat_i[15:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
endmodule // cie_host

//--- verif/tb.sv
// Testbench: instruction scenarios through the host model.
// Assumes a short initialize count for simulation.
`timescale 1ns/1ps
`include "cie_defines.svh"
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc, stb, we, ack, irq;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [15:0] q;
    int          mismatches = 0;
    int          checks = 0;
    always #12.5 clk = ~clk;
    cie_exec #(.INIT_CYCLES(10)) dut (.CLK_I(clk), .RST_N_I(rst_n),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .IRQ_O(irq));
    cie_host host (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        print_verdict();
    endtask
    task automatic chk(input string what, input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [3:0] idx);
        host.xfer(1'b0, idx, 16'h0000, q);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [15:0] d);
        host.xfer(1'b1, idx, d, q);
    endtask
    task automatic ld(input logic [63:0] k);
        for (int i = 0; i < 4; i++) wr(i[3:0], k[16*i +: 16]);
    endtask
    // Polls done only after the op write; long waits fail the run
    task automatic op(input logic [15:0] code, input int polls);
        int n;
        wr(4'h4, code);
        n = 0;
        do begin
            rd(4'h5);
            n++;
        end while (q[10] !== 1'b1 && n < polls);
        if (q[10] !== 1'b1) hang();
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(4'h5); chk("flag", q, 16'h001C);
        rd(4'h6); chk("err", q, `CIE_E_NONE);
        rd(4'h9); chk("afp", q, 16'h3FFF);
        wr(4'hB, 16'h1234); rd(4'hB); chk("unmapped", q, 16'h0000);
    endtask
    task automatic t_afull();
        wr(4'h7, 16'h0024);
        ld(64'hFFFF_0000_0000_0000); op(`CIE_OP_MASK_A, 9);
        ld(64'h2); op(`CIE_OP_AFP, 9);
        rd(4'h9); chk("afp", q, 16'h0002);
        ld(64'h1111_2222_3333_4444); op(`CIE_OP_INS_A, 9);
        op(`CIE_OP_INS_B, 9);
        op(`CIE_OP_COUNT, 9); rd(4'h0); chk("count", q, 16'h0001);
        rd(4'h5); chk("afull", q & 16'h0100, 16'h0000);
        ld(64'h5555_6666_7777_8888); op(`CIE_OP_INS_A, 9);
        rd(4'h5); chk("afull", q & 16'h0100, 16'h0100);
        chk("irq", {15'h0, irq}, 16'h0001);
    endtask
    task automatic t_check();
        ld(64'hAAAA_2222_3333_4444); op(`CIE_OP_CHECK, 3);
        rd(4'h5); chk("hit", q & 16'h0002, 16'h0002);
        rd(4'h3); chk("io3", q, 16'h1111);
        rd(4'h0); chk("io0", q, 16'h4444);
        ld(64'h0123_4567_89AB_CDEF); op(`CIE_OP_CHECK, 3);
        rd(4'h5); chk("miss", q & 16'h0002, 16'h0000);
        chk("irq", {15'h0, irq}, 16'h0001);
        ld(64'hAAAA_2222_3333_4444); op(`CIE_OP_DEL_B, 9);
        op(`CIE_OP_COUNT, 9); rd(4'h0); chk("count", q, 16'h0001);
    endtask
    task automatic t_fast();
        wr(4'h7, 16'h002F);
        op(`CIE_OP_FAST, 9);
        rd(4'h5); chk("mode", q & 16'h000C, 16'h0000);
        op(`CIE_OP_CHECK, 9);
        rd(4'h6); chk("err", q, `CIE_E_NOINIT);
        ld(64'hC234); op(`CIE_OP_PTR, 9);
        rd(4'h8); chk("ptr", q, 16'h0234);
        rd(4'h6); chk("err", q, `CIE_E_NONE);
        for (int i = 0; i < 15; i++) begin
            ld({48'h0, 16'h0100 + i[15:0]}); op(`CIE_OP_INS_A, 9);
        end
        op(`CIE_OP_COUNT, 9); rd(4'h0); chk("count", q, 16'h0010);
        ld(64'h0123_4567_89AB_CDEF); op(`CIE_OP_INS_A, 9);
        rd(4'h6); chk("err", q, `CIE_E_TFULL);
        rd(4'h5); chk("full", q & 16'h00C0, 16'h00C0);
        chk("irq", {15'h0, irq}, 16'h0001);
        wr(4'h4, `CIE_OP_INIT);
        wr(4'h0, 16'hBEEF); rd(4'h0); chk("ro", q, 16'hCDEF);
        op(`CIE_OP_COUNT, 40);
        rd(4'h5); chk("init", q & 16'h000C, 16'h000C);
        op(`CIE_OP_BUF, 9);
        op(`CIE_OP_INS_A, 9);
        rd(4'h6); chk("err", q, `CIE_E_QFULL);
        chk("irq", {15'h0, irq}, 16'h0001);
        op(16'h0008, 9);
        rd(4'h6); chk("err", q, `CIE_E_ILL);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_afull();
        t_check();
        t_fast();
        print_verdict();
    end
endmodule // tb
